// *** verilog/dma_channel_enable_status.sv ***
`timescale 1ns/1ps
`include "dma_status_defines.svh"
// Behaviour
// - Channel 1 count: 16 bits, decrements per byte
// - Channel 1 runs when enable and main
// - Channel 1 count zero clears its enable
// - Channel 1 idle with irq enable requests
// - Channel 1 enable written only with guard zero
// - Writing zero stops channel 1, restartable
// - Writing one enables channel 1, sets main
// - Channel 0 runs when enable and main
// - Channel 0 count zero clears its enable
// - Channel 0 enable written only with guard zero
// - Channel 0 write one enables, zero disables
// - Guard bits write-only, always read one
// - Channel 0 idle with irq enable requests
// - Non-maskable interrupt clears main enable
// - Main enable read-only, set via channel enables
// - Reset clears enables and irq enables

module dma_channel_enable_status
   import dma_status_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] IO_ADDR_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   input wire logic [7:0] IO_WDATA_I,
   output logic [7:0] IO_RDATA_O,
   input wire logic NMI_I,
   input wire logic CHAN0_BYTE_DONE_I,
   input wire logic CHAN1_BYTE_DONE_I,
   output logic CHAN0_RUN_O,
   output logic CHAN1_RUN_O,
   output logic DMA_IRQ_O
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   // NMI comes from a pin; two stages before use
   logic nmi_meta;
   logic nmi_sync;
   logic nmi_prev;
   logic next_nmi_meta;
   logic next_nmi_sync;
   logic next_nmi_prev;

   // Second stage is the only reader of the first
   always_comb
   begin
      next_nmi_meta = NMI_I;
      next_nmi_sync = nmi_meta;
      next_nmi_prev = nmi_sync;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         nmi_meta <= 1'b0;
         nmi_sync <= 1'b0;
         nmi_prev <= 1'b0;
      end
      else
      begin
         nmi_meta <= next_nmi_meta;
         nmi_sync <= next_nmi_sync;
         nmi_prev <= next_nmi_prev;
      end
   end

   // Edge taken so a held level does not block restarts
   logic nmi_event;
   assign nmi_event = nmi_sync && !nmi_prev;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // ****************************************
   // Access class
   // ****************************************
   // Anything unmapped reads as zero and ignores writes
   function automatic acc_kind_t kind_of(input logic [7:0] addr);
      kind_of = ACC_NONE;
      if (hit(addr, `OFS_STATUS_ENABLE))
      begin
         kind_of = ACC_STATUS;
      end
      else if (hit(addr, `OFS_CHAN0_COUNT_LO) || hit(addr, `OFS_CHAN0_COUNT_HI))
      begin
         kind_of = ACC_COUNT;
      end
      else if (hit(addr, `OFS_CHAN1_COUNT_LO) || hit(addr, `OFS_CHAN1_COUNT_HI))
      begin
         kind_of = ACC_COUNT;
      end
   endfunction : kind_of

   acc_kind_t wr_kind;
   acc_kind_t rd_kind;
   logic wr_status;
   logic wr_c0_lo;
   logic wr_c0_hi;
   logic wr_c1_lo;
   logic wr_c1_hi;

   assign wr_kind = IO_WR_I ? kind_of(IO_ADDR_I) : ACC_NONE;
   assign rd_kind = IO_RD_I ? kind_of(IO_ADDR_I) : ACC_NONE;
   assign wr_status = (wr_kind == ACC_STATUS);
   assign wr_c0_lo = IO_WR_I && hit(IO_ADDR_I, `OFS_CHAN0_COUNT_LO);
   assign wr_c0_hi = IO_WR_I && hit(IO_ADDR_I, `OFS_CHAN0_COUNT_HI);
   assign wr_c1_lo = IO_WR_I && hit(IO_ADDR_I, `OFS_CHAN1_COUNT_LO);
   assign wr_c1_hi = IO_WR_I && hit(IO_ADDR_I, `OFS_CHAN1_COUNT_HI);

   // ****************************************
   // Byte counters
   // ****************************************
   logic chan0_enable;
   logic chan1_enable;
   logic main_transfer_enable;
   logic chan0_run;
   logic chan1_run;
   count_t chan0_byte_count;
   count_t chan1_byte_count;
   logic dec0;
   logic dec1;

   // Channel 0 counts only while it runs
   assign dec0 = CHAN0_BYTE_DONE_I && chan0_run;
   // Channel 1 counts only while it runs
   assign dec1 = CHAN1_BYTE_DONE_I && chan1_run;

   byte_counter #(.WIDTH(16)) u_chan0_count (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .wr_lo_i(wr_c0_lo),
      .wr_hi_i(wr_c0_hi),
      .wdata_i(IO_WDATA_I),
      .dec_i(dec0),
      .count_o(chan0_byte_count),
      .zero_o()
   );

   byte_counter #(.WIDTH(16)) u_chan1_count (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .wr_lo_i(wr_c1_lo),
      .wr_hi_i(wr_c1_hi),
      .wdata_i(IO_WDATA_I),
      .dec_i(dec1),
      .count_o(chan1_byte_count),
      .zero_o()
   );

   // ****************************************
   // Enable state
   // ****************************************
   logic chan0_done_irq_enable;
   logic chan1_done_irq_enable;
   logic next_chan0_enable;
   logic next_chan1_enable;
   logic next_main;
   logic next_ie0;
   logic next_ie1;
   logic last0;
   logic last1;

   // Last byte: a counted byte while the count reads one this cycle
   assign last0 = dec0 && (chan0_byte_count == 16'h0001);
   assign last1 = dec1 && (chan1_byte_count == 16'h0001);

   always_comb
   begin
      next_chan0_enable = chan0_enable;
      next_chan1_enable = chan1_enable;
      next_main = main_transfer_enable;
      next_ie0 = chan0_done_irq_enable;
      next_ie1 = chan1_done_irq_enable;
      if (wr_status)
      begin
         next_ie0 = IO_WDATA_I[`BIT_CHAN0_IRQ_EN];
         next_ie1 = IO_WDATA_I[`BIT_CHAN1_IRQ_EN];
         if (!IO_WDATA_I[`BIT_CHAN0_GUARD])
         begin
            next_chan0_enable = IO_WDATA_I[`BIT_CHAN0_ENABLE];
            if (IO_WDATA_I[`BIT_CHAN0_ENABLE])
            begin
               next_main = 1'b1;
            end
         end
         if (!IO_WDATA_I[`BIT_CHAN1_GUARD])
         begin
            next_chan1_enable = IO_WDATA_I[`BIT_CHAN1_ENABLE];
            if (IO_WDATA_I[`BIT_CHAN1_ENABLE])
            begin
               next_main = 1'b1;
            end
         end
      end
      if (last0)
      begin
         next_chan0_enable = 1'b0;
      end
      if (last1)
      begin
         next_chan1_enable = 1'b0;
      end
      // Non-maskable clears main; wins over a write
      if (nmi_event)
      begin
         next_main = 1'b0;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         chan0_enable <= `RST_CTRL;
         chan1_enable <= `RST_CTRL;
         main_transfer_enable <= `RST_CTRL;
         chan0_done_irq_enable <= `RST_CTRL;
         chan1_done_irq_enable <= `RST_CTRL;
      end
      else
      begin
         chan0_enable <= next_chan0_enable;
         chan1_enable <= next_chan1_enable;
         main_transfer_enable <= next_main;
         chan0_done_irq_enable <= next_ie0;
         chan1_done_irq_enable <= next_ie1;
      end
   end

   // ****************************************
   // Run and interrupt
   // ****************************************
   // Channel 0 and channel 1 gates
   assign chan0_run = chan0_enable && main_transfer_enable;
   assign chan1_run = chan1_enable && main_transfer_enable;
   assign CHAN0_RUN_O = chan0_run;
   assign CHAN1_RUN_O = chan1_run;

   // ****************************************
   // Interrupt request
   // ****************************************
   // Terms use next values so the level moves with the enable itself
   logic pend0;
   logic pend1;
   logic next_irq;
   logic irq;

   always_comb
   begin
      pend0 = !next_chan0_enable && next_ie0;
      pend1 = !next_chan1_enable && next_ie1;
      // A level, held while either term stands
      next_irq = pend0 || pend1;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= next_irq;
      end
   end
   assign DMA_IRQ_O = irq;

   // ****************************************
   // Read mux
   // ****************************************
   // Registered so read data is stable one cycle after the strobe
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic [7:0] status_view;

   always_comb
   begin
      status_view = 8'h00;
      status_view[`BIT_CHAN1_ENABLE] = chan1_enable;
      status_view[`BIT_CHAN0_ENABLE] = chan0_enable;
      status_view[`BIT_CHAN1_GUARD] = 1'b1;
      status_view[`BIT_CHAN0_GUARD] = 1'b1;
      status_view[`BIT_CHAN1_IRQ_EN] = chan1_done_irq_enable;
      status_view[`BIT_CHAN0_IRQ_EN] = chan0_done_irq_enable;
      status_view[`BIT_MAIN_ENABLE] = main_transfer_enable;
      next_rdata = 8'h00;
      if (rd_kind != ACC_NONE)
      begin
         unique case (IO_ADDR_I)
            `OFS_CHAN0_COUNT_LO: next_rdata = chan0_byte_count[7:0];
            `OFS_CHAN0_COUNT_HI: next_rdata = chan0_byte_count[15:8];
            `OFS_CHAN1_COUNT_LO: next_rdata = chan1_byte_count[7:0];
            `OFS_CHAN1_COUNT_HI: next_rdata = chan1_byte_count[15:8];
            `OFS_STATUS_ENABLE: next_rdata = status_view;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end
   assign IO_RDATA_O = rdata;
endmodule : dma_channel_enable_status

// *** verilog/dma_status_defines.svh ***
`ifndef DMA_STATUS_DEFINES_SVH
`define DMA_STATUS_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CHAN0_COUNT_LO 8'h26
`define OFS_CHAN0_COUNT_HI 8'h27
`define OFS_CHAN1_COUNT_LO 8'h2e
`define OFS_CHAN1_COUNT_HI 8'h2f
`define OFS_STATUS_ENABLE 8'h30

// ****************************************
// Status register fields
// ****************************************
`define BIT_CHAN1_ENABLE 7
`define BIT_CHAN0_ENABLE 6
`define BIT_CHAN1_GUARD 5
`define BIT_CHAN0_GUARD 4
`define BIT_CHAN1_IRQ_EN 3
`define BIT_CHAN0_IRQ_EN 2
`define BIT_MAIN_ENABLE 0

// ****************************************
// Reset values
// ****************************************
`define RST_COUNT 16'h0000
`define RST_CTRL 1'b0

`endif

// *** verilog/dma_status_pkg.sv ***
package dma_status_pkg;
   typedef enum logic [1:0] {ACC_NONE, ACC_COUNT, ACC_STATUS} acc_kind_t;
   typedef logic [15:0] count_t;
endpackage : dma_status_pkg

// *** verilog/byte_counter.sv ***
`timescale 1ns/1ps
`include "dma_status_defines.svh"

module byte_counter
   import dma_status_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [7:0] wdata_i,
   input wire logic dec_i,
   output logic [WIDTH-1:0] count_o,
   output logic zero_o
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   always_comb
   begin
      next_count = count;
      if (wr_lo_i)
      begin
         next_count[7:0] = wdata_i;
      end
      else if (wr_hi_i)
      begin
         next_count[WIDTH-1:8] = wdata_i[WIDTH-9:0];
      end
      else if (dec_i && (count != '0))
      begin
         next_count = count - WIDTH'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         count <= WIDTH'(`RST_COUNT);
      end
      else
      begin
         count <= next_count;
      end
   end

   assign count_o = count;
   assign zero_o = (count == '0);
endmodule : byte_counter

// *** verif/dma_status_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module dma_status_checker
   import dma_status_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] IO_ADDR_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   input wire logic [7:0] IO_WDATA_I,
   input wire logic [7:0] IO_RDATA_O,
   input wire logic NMI_I,
   input wire logic CHAN0_BYTE_DONE_I,
   input wire logic CHAN1_BYTE_DONE_I,
   input wire logic CHAN0_RUN_O,
   input wire logic CHAN1_RUN_O,
   input wire logic DMA_IRQ_O
);
   logic [7:0] wd;
   logic st_wr;
   logic st_rd;
   logic calm;
   assign wd = IO_WDATA_I;
   assign st_wr = IO_WR_I && IO_ADDR_I == 8'h30;
   assign st_rd = IO_RD_I && !IO_WR_I && IO_ADDR_I == 8'h30;
   // Byte pulses and NMI may legally beat a write, so those cycles are left out
   assign calm = st_wr && !NMI_I && !CHAN0_BYTE_DONE_I && !CHAN1_BYTE_DONE_I;
   default clocking dc @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   a_ch1_write_on: assert property (calm && wd[7] && !wd[5] |=> CHAN1_RUN_O)
      else $error("ch1 enable write lost");
   a_ch0_write_on: assert property (calm && wd[6] && !wd[4] |=> CHAN0_RUN_O)
      else $error("ch0 enable write lost");
   a_ch1_write_off: assert property (st_wr && !wd[7] && !wd[5] |=> !CHAN1_RUN_O)
      else $error("ch1 still running");
   a_guard_holds:
      assert property (calm && wd[5] && wd[4] |=> $stable({CHAN1_RUN_O, CHAN0_RUN_O}))
      else $error("guarded write changed enables");
   a_guard_reads: assert property (st_rd |=> IO_RDATA_O[5:4] == 2'b11)
      else $error("guard bits not one");
   a_status_run:
      assert property (st_rd |=> (IO_RDATA_O[7] & IO_RDATA_O[0]) == $past(CHAN1_RUN_O)
         && (IO_RDATA_O[6] & IO_RDATA_O[0]) == $past(CHAN0_RUN_O))
      else $error("status and run disagree");
   a_nmi_halts: assert property ($rose(NMI_I) |-> ##[1:4] !CHAN0_RUN_O && !CHAN1_RUN_O)
      else $error("NMI did not halt");
   a_irq_level:
      assert property (!IO_WR_I && !CHAN0_BYTE_DONE_I && !CHAN1_BYTE_DONE_I
         |=> $stable(DMA_IRQ_O))
      else $error("irq level moved");
   c_enable: cover property (calm && wd[7] && !wd[5]);
   c_nmi: cover property ($rose(NMI_I));
   c_done: cover property ($fell(CHAN1_RUN_O) && !IO_WR_I);
endmodule : dma_status_checker

// *** verif/host_cpu_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host NMI source
// ****************************************
module host_cpu_model
(
   input wire logic clk_i,
   input wire logic nmi_req_i,
   output logic nmi_o
);
   logic [2:0] hold = 3'h0;
   // NMI pin pulse
   // Held four cycles so the two-stage synchroniser cannot miss it
   always @(posedge clk_i)
      hold <= nmi_req_i ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
   assign nmi_o = hold != 3'h0;
endmodule : host_cpu_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
bind dma_channel_enable_status dma_status_checker chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
   .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .IO_WDATA_I(IO_WDATA_I),
   .IO_RDATA_O(IO_RDATA_O), .NMI_I(NMI_I), .CHAN0_BYTE_DONE_I(CHAN0_BYTE_DONE_I),
   .CHAN1_BYTE_DONE_I(CHAN1_BYTE_DONE_I), .CHAN0_RUN_O(CHAN0_RUN_O),
   .CHAN1_RUN_O(CHAN1_RUN_O), .DMA_IRQ_O(DMA_IRQ_O));
// ****************************************
// Bench top
// ****************************************
module testbench
   import dma_status_pkg::*;
;
   logic MCLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic [7:0] IO_ADDR_I = 8'h00;
   logic IO_WR_I = 1'b0;
   logic IO_RD_I = 1'b0;
   logic [7:0] IO_WDATA_I = 8'h00;
   logic NMI_I;
   logic CHAN0_BYTE_DONE_I = 1'b0;
   logic CHAN1_BYTE_DONE_I = 1'b0;
   logic [7:0] IO_RDATA_O;
   logic CHAN0_RUN_O;
   logic CHAN1_RUN_O;
   logic DMA_IRQ_O;
   logic nmi_req = 1'b0;
   logic rd_seen = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [10:0] exp_q[$];
   logic [10:0] e;
   logic [1:0] en = 2'b00;
   logic [1:0] ie = 2'b00;
   logic main = 1'b0;
   count_t cnt[2] = '{16'h0000, 16'h0000};
   logic [7:0] ra[6] = '{8'h26, 8'h27, 8'h2e, 8'h2f, 8'h30, 8'h31};
   logic [31:0] r;
   logic [7:0] lo;
   dma_channel_enable_status dut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .IO_ADDR_I(IO_ADDR_I),
      .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O),
      .NMI_I(NMI_I), .CHAN0_BYTE_DONE_I(CHAN0_BYTE_DONE_I),
      .CHAN1_BYTE_DONE_I(CHAN1_BYTE_DONE_I), .CHAN0_RUN_O(CHAN0_RUN_O),
      .CHAN1_RUN_O(CHAN1_RUN_O), .DMA_IRQ_O(DMA_IRQ_O));
   host_cpu_model cpu (.clk_i(MCLK_I), .nmi_req_i(nmi_req), .nmi_o(NMI_I));
   initial
      forever #50 MCLK_I = ~MCLK_I;
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   // One bus cycle; the reference state moves with it
   task automatic drv(logic w, logic rq, logic [7:0] a, logic [7:0] d, logic [1:0] b);
      logic [7:0] rv;
      @(negedge MCLK_I);
      {IO_WR_I, IO_RD_I, IO_ADDR_I, IO_WDATA_I} = {w, rq, a, d};
      {CHAN1_BYTE_DONE_I, CHAN0_BYTE_DONE_I} = b;
      if (w && a == 8'h30)
      begin
         for (int i = 0; i < 2; i++)
            if (!d[4 + i])
            begin
               en[i] = d[6 + i];
               main = main | d[6 + i];
            end
         ie = d[3:2];
      end
      if (w && (a[7:1] == 7'h13 || a[7:1] == 7'h17))
         cnt[a[3]][8 * a[0] +: 8] = d;
      for (int i = 0; i < 2; i++)
         if (b[i] && en[i] && main && cnt[i] != 16'h0000)
         begin
            cnt[i] = cnt[i] - 16'h0001;
            en[i] = cnt[i] != 16'h0000;
         end
      rv = a[7:1] == 7'h13 || a[7:1] == 7'h17 ? cnt[a[3]][8 * a[0] +: 8] : 8'h00;
      if (a == 8'h30)
         rv = {en, 2'b11, ie, 1'b0, main};
      if (rq)
         exp_q.push_back({|(~en & ie), en[1] & main, en[0] & main, rv});
   endtask : drv
   task automatic wr(logic [7:0] a, logic [7:0] d);
      drv(1'b1, 1'b0, a, d, 2'b00);
   endtask : wr
   task automatic rd(logic [7:0] a);
      drv(1'b0, 1'b1, a, 8'h00, 2'b00);
   endtask : rd
   always @(posedge MCLK_I)
   begin
      rd_seen <= IO_RD_I;
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         test_done();
      end
   end
   always @(negedge MCLK_I)
      if (rd_seen && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         num_checks++;
         if ({DMA_IRQ_O, CHAN1_RUN_O, CHAN0_RUN_O, IO_RDATA_O} !== e)
         begin
            bad_count++;
            $display("ERROR irq_run_rdata expected %h seen %h", e,
               {DMA_IRQ_O, CHAN1_RUN_O, CHAN0_RUN_O, IO_RDATA_O});
         end
      end
   initial
   begin
      void'($urandom(41083));
      repeat (6) @(posedge MCLK_I);
      @(negedge MCLK_I);
      RST_N_I = 1'b1;
      rd(8'h30);
      rd(8'h31);
      wr(8'h30, 8'h80);
      rd(8'h30);
      wr(8'h30, 8'h31);
      rd(8'h30);
      for (int c = 0; c < 2; c++)
      begin
         lo = c ? 8'h2e : 8'h26;
         wr(lo, 8'h03);
         wr(lo + 8'h01, 8'h00);
         wr(8'h30, c ? 8'h88 : 8'h44);
         drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b01 << c);
         wr(8'h30, c ? 8'h18 : 8'h24);
         drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b01 << c);
         rd(lo);
         wr(8'h30, c ? 8'h88 : 8'h44);
         repeat (3) drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b01 << c);
         rd(8'h30);
         rd(lo);
      end
      wr(8'h30, 8'hcc);
      nmi_req = 1'b1;
      drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b00);
      nmi_req = 1'b0;
      repeat (8) drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b00);
      main = 1'b0;
      rd(8'h30);
      wr(8'h30, 8'hcc);
      rd(8'h30);
      repeat (60)
      begin
         r = $urandom;
         if (r[9:8] == 2'b00)
            wr(8'h30, r[7:0]);
         else if (r[9:8] == 2'b01)
            wr(r[10] ? 8'h2e : 8'h26, {5'h00, r[2:0]});
         else if (r[9:8] == 2'b10)
            drv(1'b0, 1'b0, 8'h00, 8'h00, r[1:0]);
         else
            rd(ra[r[2:0] % 6]);
      end
      repeat (3) drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b00);
      // Second reset in mid-run; the reference returns to rest with it
      RST_N_I = 1'b0;
      repeat (2) @(negedge MCLK_I);
      RST_N_I = 1'b1;
      {en, ie, main} = 5'h00;
      cnt = '{16'h0000, 16'h0000};
      rd(8'h30);
      rd(8'h2e);
      repeat (2) drv(1'b0, 1'b0, 8'h00, 8'h00, 2'b00);
      test_done();
   end
endmodule : testbench
